/* logic/fscm_pkg.sv */
// Constants, register map and types shared by the flash syscall mailbox.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package fscm_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam int          ADDR_W        = 5;
   localparam logic [4:0]  OFS_LOCK      = 5'h00;
   localparam logic [4:0]  OFS_DATA      = 5'h04;
   localparam logic [4:0]  OFS_NOTIFY    = 5'h08;
   localparam logic [4:0]  OFS_STATUS    = 5'h0c;
   localparam logic [4:0]  OFS_CTRL      = 5'h10;

   // Status and control register bit positions
   localparam int          ST_LOCK       = 0;
   localparam int          ST_BUSY       = 1;
   localparam int          ST_RELEASE    = 2;
   localparam int          ST_NOTIFY     = 3;
   localparam int          ST_RESULT     = 4;
   localparam int          CTRL_PERMIT   = 0;

   // Parameter block field positions
   localparam int          OPC_LSB       = 24;
   localparam int          SKIP_LSB      = 16;
   localparam int          BLOCK_LSB     = 8;
   localparam int          MASK_LSB      = 24;
   localparam int          LOC_LSB       = 8;
   localparam int          SIZE_LSB      = 0;

   // Opcodes and field codes
   localparam logic [7:0]  OP_ERASE_ALL  = 8'h0a;
   localparam logic [7:0]  OP_PROGRAM    = 8'h06;
   localparam logic [7:0]  SIZE_64       = 8'h03;
   localparam logic [7:0]  LOC_LATCH     = 8'h00;

   // Completion codes written back into word 0
   localparam logic [31:0] CODE_OK       = 32'ha000_0000;
   localparam logic [31:0] CODE_FAIL     = 32'hf000_0001;

   // Parameter store: words 0..3 of the block, then two data words
   localparam int          NWORDS        = 6;
   localparam logic [2:0]  IDX_LAST_HDR  = 3'd3;
   localparam logic [2:0]  IDX_LAST      = 3'd5;

   // Reset values
   localparam logic [31:0] DATA_RST      = 32'h0000_0000;
   localparam logic        PERMIT_RST    = 1'b0;

   typedef enum logic [2:0] {
      S_IDLE, S_READ, S_DECODE, S_FLASH, S_WRITE, S_RELEASE
   } fscm_state_t;

endpackage

/* logic/fscm_mem_port.sv */
// Single-word shared memory access port of the mailbox executor.
// Assumes memory answers each held request with a one-cycle mem_ack.
`timescale 1ns/1ns
module fscm_mem_port (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        start,
   input  wire logic        we,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   output logic             done,
   output logic [31:0]      rdata,
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata
);

   // Request held from start until memory acknowledges
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
      end else if (start && !mem_req) begin
         mem_req   <= 1'b1;
         mem_we    <= we;
         mem_addr  <= addr;
         mem_wdata <= wdata;
      end else if (mem_req && mem_ack) begin
         mem_req   <= 1'b0;
      end
   end

   // Completion pulse and captured read word
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         done  <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         done <= mem_req && mem_ack;
         if (mem_req && mem_ack && !mem_we) begin
            rdata <= mem_rdata;
         end
      end
   end

endmodule

/* logic/fscm_mailbox.sv */
// Flash syscall mailbox: lockable channel, command fetch, flash dispatch.
// Assumes one clock, synchronous memory and flash handshakes, and that the
// requester keeps its own side of the channel protocol.
//
// How it works
// - Erase-all opcode 0x0a in top byte
// - Notify write raises notification toward executor
// - Executor reads block address, then word 0
// - Unknown opcode writes failure code to word 0
// - Erase-all hits code array only
// - Success or failure code written after command
// - Completion fires release trigger and interrupt
// - Program word 0: opcode, skip-check, blocking flags
// - Word 1: interrupt mask, location, size 0x03
// - Word 2 target address, word 3 buffer address
// - Program reads all fields then programs row
`timescale 1ns/1ns
module fscm_mailbox (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic [fscm_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   input  wire logic [3:0]               avs_byteenable,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest,
   output logic                          mem_req,
   output logic                          mem_we,
   output logic [31:0]                   mem_addr,
   output logic [31:0]                   mem_wdata,
   input  wire logic                     mem_ack,
   input  wire logic [31:0]              mem_rdata,
   output logic                          fl_req,
   output logic                          fl_erase_all,
   output logic [31:0]                   fl_addr,
   output logic [63:0]                   fl_data,
   output logic                          fl_skip_blank,
   output logic                          fl_blocking,
   output logic [7:0]                    fl_irq_mask,
   input  wire logic                     fl_done,
   input  wire logic                     fl_fail,
   output logic                          main_array_write_permit,
   output logic                          syscall_irq_line,
   output logic                          release_irq_line
);
   import fscm_pkg::*;

   // Byte field of a parameter word
   function automatic logic [7:0] field8(input logic [31:0] w, input int lsb);
      logic [31:0] s;
      s = w >> lsb;
      return s[7:0];
   endfunction

   // Byte address of word idx above a base
   function automatic logic [31:0] word_addr(input logic [31:0] base,
                                             input logic [2:0]  idx);
      return base + {27'h0, idx, 2'b00};
   endfunction

   fscm_state_t       state_q;
   logic [31:0]       par_q [NWORDS];
   logic [2:0]        idx_q;
   logic [31:0]       blk_q;
   logic [31:0]       data_word_q;
   logic              lock_q;
   logic              notify_q;
   logic              release_q;
   logic              ok_q;
   logic              issued_q;
   logic              resp_q;
   logic              permit_q;
   logic              acc_wr;
   logic              rd_first;
   logic              notify_hit;
   logic              release_clr;
   logic              release_fire;
   logic              mem_start;
   logic              mem_done;
   logic [31:0]       mem_rd;
   logic [31:0]       start_addr;
   logic [7:0]        opcode;
   logic [31:0]       rd_value;

   // Avalon-MM slave: one wait cycle, then the access completes
   assign avs_waitrequest = (avs_read || avs_write) && !resp_q;
   assign rd_first        = avs_read && !resp_q;
   assign acc_wr          = avs_write && resp_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         resp_q <= 1'b0;
      end else begin
         resp_q <= (avs_read || avs_write) && !resp_q;
      end
   end

   // Read mux of the register file
   always_comb begin
      rd_value = 32'h0000_0000;
      case (avs_address)
         OFS_LOCK:   rd_value = {31'h0, !lock_q};
         OFS_DATA:   rd_value = data_word_q;
         OFS_STATUS: begin
            rd_value[ST_LOCK]    = lock_q;
            rd_value[ST_BUSY]    = (state_q != S_IDLE);
            rd_value[ST_RELEASE] = release_q;
            rd_value[ST_NOTIFY]  = notify_q;
            rd_value[ST_RESULT]  = ok_q;
         end
         OFS_CTRL:   rd_value = {31'h0, permit_q};
         default:    rd_value = 32'h0000_0000;
      endcase
   end

   // Read data captured in the wait cycle, stands at the completing edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_first) begin
         avs_readdata <= rd_value;
      end
   end

   // Channel lock: a read of the lock register acquires it when free
   assign release_fire = (state_q == S_RELEASE);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lock_q <= 1'b0;
      end else if (release_fire) begin
         lock_q <= 1'b0;
      end else if (rd_first && avs_address == OFS_LOCK) begin
         lock_q <= 1'b1;
      end
   end

   // Channel data word, byte lanes honoured
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         data_word_q <= DATA_RST;
      end else if (acc_wr && avs_address == OFS_DATA) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) begin
               data_word_q[b*8 +: 8] <= avs_writedata[b*8 +: 8];
            end
         end
      end
   end

   // Main array write permit control bit
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         permit_q <= PERMIT_RST;
      end else if (acc_wr && avs_address == OFS_CTRL && avs_byteenable[0]) begin
         permit_q <= avs_writedata[CTRL_PERMIT];
      end
   end
   assign main_array_write_permit = permit_q;

   // Notify trigger: only a locked, idle channel accepts it
   assign notify_hit = acc_wr && avs_address == OFS_NOTIFY && avs_byteenable[0]
                       && avs_writedata[0] && lock_q && state_q == S_IDLE;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         notify_q <= 1'b0;
      end else if (notify_hit) begin
         notify_q <= 1'b1;
      end else if (state_q == S_IDLE) begin
         notify_q <= 1'b0;
      end
   end
   assign syscall_irq_line = notify_q;

   // Release flag: sticky, write one to clear, a new release wins
   assign release_clr = acc_wr && avs_address == OFS_STATUS && avs_byteenable[0]
                        && avs_writedata[ST_RELEASE];
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         release_q <= 1'b0;
      end else if (release_fire) begin
         release_q <= 1'b1;
      end else if (release_clr) begin
         release_q <= 1'b0;
      end
   end
   assign release_irq_line = release_q;

   // Opcode of the fetched word 0, other bits of the word ignored
   assign opcode = field8(par_q[0], OPC_LSB);

   // Address of the next memory access
   always_comb begin
      if (state_q == S_WRITE) begin
         start_addr = blk_q;
      end else if (idx_q <= IDX_LAST_HDR) begin
         start_addr = word_addr(blk_q, idx_q);
      end else begin
         start_addr = word_addr(par_q[3], idx_q - 3'd4);
      end
   end

   assign mem_start = (state_q == S_READ || state_q == S_WRITE) && !issued_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         issued_q <= 1'b0;
      end else if (mem_done) begin
         issued_q <= 1'b0;
      end else if (mem_start) begin
         issued_q <= 1'b1;
      end
   end

   fscm_mem_port u_mem (
      .clk       (clk),
      .rst_n     (rst_n),
      .start     (mem_start),
      .we        (state_q == S_WRITE),
      .addr      (start_addr),
      .wdata     (ok_q ? CODE_OK : CODE_FAIL),
      .done      (mem_done),
      .rdata     (mem_rd),
      .mem_req   (mem_req),
      .mem_we    (mem_we),
      .mem_addr  (mem_addr),
      .mem_wdata (mem_wdata),
      .mem_ack   (mem_ack),
      .mem_rdata (mem_rdata)
   );

   // Parameter store filled by index
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NWORDS; i++) begin
            par_q[i] <= 32'h0000_0000;
         end
      end else if (state_q == S_READ && mem_done) begin
         par_q[idx_q] <= mem_rd;
      end
   end

   // Command sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         idx_q   <= 3'd0;
         blk_q   <= 32'h0000_0000;
         ok_q    <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (notify_q) begin
                  blk_q   <= data_word_q;
                  idx_q   <= 3'd0;
                  state_q <= S_READ;
               end
            end
            S_READ: begin
               if (mem_done) begin
                  if (idx_q == 3'd0 && field8(mem_rd, OPC_LSB) != OP_PROGRAM) begin
                     state_q <= S_DECODE;
                  end else if (idx_q == IDX_LAST) begin
                     state_q <= S_DECODE;
                  end else begin
                     idx_q <= idx_q + 3'd1;
                  end
               end
            end
            S_DECODE: begin
               ok_q <= 1'b0;
               if (opcode == OP_ERASE_ALL && permit_q) begin
                  state_q <= S_FLASH;
               end else if (opcode == OP_PROGRAM && permit_q
                            && field8(par_q[1], SIZE_LSB) == SIZE_64
                            && field8(par_q[1], LOC_LSB) == LOC_LATCH) begin
                  state_q <= S_FLASH;
               end else begin
                  state_q <= S_WRITE;
               end
            end
            S_FLASH: begin
               if (fl_done) begin
                  ok_q    <= !fl_fail;
                  state_q <= S_WRITE;
               end
            end
            S_WRITE: begin
               if (mem_done) begin
                  state_q <= S_RELEASE;
               end
            end
            S_RELEASE: begin
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // Flash controller request, held until done
   assign fl_req        = (state_q == S_FLASH);
   assign fl_erase_all  = (opcode == OP_ERASE_ALL);
   assign fl_addr       = par_q[2];
   assign fl_data       = {par_q[5], par_q[4]};
   assign fl_skip_blank = field8(par_q[0], SKIP_LSB) != 8'h00;
   assign fl_blocking   = field8(par_q[0], BLOCK_LSB) != 8'h00;
   assign fl_irq_mask   = fl_blocking ? 8'h00 : field8(par_q[1], MASK_LSB);

   // Checks on the sequencer and the bus slave
   notify_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_q == S_IDLE && notify_q |=> state_q == S_READ && idx_q == 3'd0
      && blk_q == $past(data_word_q))
      else $error("notify did not start a fetch from the data word");

   first_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(mem_req) && !mem_we && idx_q == 3'd0 |-> mem_addr == blk_q)
      else $error("first fetch not at block address");

   unknown_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_q == S_DECODE && opcode != OP_ERASE_ALL && opcode != OP_PROGRAM
      |=> state_q == S_WRITE && !ok_q)
      else $error("unknown opcode not failed");

   erase_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      fl_req && fl_erase_all |-> par_q[0][31:24] == OP_ERASE_ALL && permit_q)
      else $error("erase request without erase opcode");

   status_code_a: assert property (@(posedge clk) disable iff (!rst_n)
      mem_req && mem_we |-> mem_addr == blk_q
      && mem_wdata == (ok_q ? CODE_OK : CODE_FAIL))
      else $error("wrong status word written");

   flash_result_a: assert property (@(posedge clk) disable iff (!rst_n)
      fl_req && fl_done |=> state_q == S_WRITE && ok_q == !$past(fl_fail))
      else $error("flash result not recorded");

   release_frees_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_q == S_RELEASE |=> !lock_q && release_irq_line && state_q == S_IDLE)
      else $error("release did not free the lock");

   program_fields_a: assert property (@(posedge clk) disable iff (!rst_n)
      fl_req && !fl_erase_all |-> fl_addr == par_q[2]
      && fl_data[31:0] == par_q[4] && par_q[1][7:0] == SIZE_64
      && par_q[1][15:8] == LOC_LATCH && par_q[0][31:24] == OP_PROGRAM && permit_q)
      else $error("program row fields wrong");

   bus_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus access not answered after one wait cycle");

endmodule

/* sim/fscm_far_model.sv */
// Far side of the mailbox: shared word store and a flash engine.
// Assumes requests are held until answered, as the mailbox promises.
`timescale 1ns/1ns
module fscm_far_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic        fail,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata,
   input  wire logic        fl_req,
   output logic             fl_done,
   output logic             fl_fail
);
   logic [31:0] mem [16];
   logic [2:0]  mcnt_q;
   logic [2:0]  fcnt_q;
   logic        served_q;

   // Word store, answers after zero or three wait cycles
   always @(posedge clk) begin
      if (!rst_n) begin
         mem_ack   <= 1'b0;
         mcnt_q    <= 3'h0;
         mem_rdata <= 32'h0;
      end else if (mem_ack) begin
         mem_ack   <= 1'b0;
         mcnt_q    <= 3'h0;
         mem_rdata <= ~mem_rdata;  // Released bus shows no stale word
      end else if (mem_req && mcnt_q == (slow ? 3'h3 : 3'h0)) begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr[5:2]];
         if (mem_we) begin
            mem[mem_addr[5:2]] <= mem_wdata;
         end
      end else if (mem_req) begin
         mcnt_q <= mcnt_q + 3'h1;
      end
   end

   // Flash engine, one done pulse per request, fail only with done
   always @(posedge clk) begin
      fl_done <= 1'b0;
      fl_fail <= 1'b0;
      if (!rst_n || !fl_req) begin
         fcnt_q   <= 3'h0;
         served_q <= 1'b0;
      end else if (!served_q && fcnt_q == (slow ? 3'h5 : 3'h1)) begin
         fl_done  <= 1'b1;
         fl_fail  <= fail;
         served_q <= 1'b1;
      end else if (!served_q) begin
         fcnt_q <= fcnt_q + 3'h1;
      end
   end
endmodule

/* sim/fscm_mailbox_bench.sv */
// Self-checking bench of the flash syscall mailbox.
// Assumes the far-side model stands on the memory and flash ports.
`timescale 1ns/1ns
module fscm_mailbox_bench;
   import fscm_pkg::*;
   typedef struct {
      logic [31:0] w0, w1, w2, d0;
      logic        permit, fail, op, erase;
      logic [9:0]  flags;
      logic [31:0] code;
   } fscm_row_t;
   logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, slow = 0, fail = 0;
   logic [4:0] avs_address = 5'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, mem_addr, mem_wdata, mem_rdata;
   logic [31:0] fl_addr, rd, ad_s;
   logic [3:0] avs_byteenable = 4'hf;
   logic avs_waitrequest, mem_req, mem_we, mem_ack, fl_req, fl_erase_all, fl_skip_blank;
   logic fl_blocking, fl_done, fl_fail, main_array_write_permit, syscall_irq_line;
   logic release_irq_line, fr_p, ir_p, er_s;
   logic [63:0] fl_data, da_s;
   logic [7:0] fl_irq_mask;
   logic [9:0] fg_s;
   int err_count = 0, comparisons = 0, cyc = 0, fl_cnt = 0, irq_cnt = 0, n_fl, n_irq;
   fscm_row_t r;
   fscm_row_t rows [10] = '{
      '{32'h0a00_0000, 0, 0, 0, 1, 0, 1, 1, 0, CODE_OK},
      '{32'h0a00_0000, 0, 0, 0, 1, 1, 1, 1, 0, CODE_FAIL},
      '{32'h0600_0000, 32'h5a7f_0003, 32'h1000_0000, 32'h55aa_55aa, 1, 0, 1, 0,
        10'h05a, CODE_OK},
      '{32'h0601_0100, 32'h5a00_0003, 32'h1000_0008, 32'h0f1e_2d3c, 1, 0, 1, 0,
        10'h300, CODE_OK},
      '{32'h0600_0000, 32'h3, 32'h1000_0010, 32'h89ab_cdef, 1, 1, 1, 0, 0, CODE_FAIL},
      '{32'h0700_0000, 0, 0, 0, 1, 0, 0, 0, 0, CODE_FAIL},
      '{32'h0a12_3456, 0, 0, 0, 1, 0, 1, 1, 0, CODE_OK},
      '{32'h0600_0000, 32'h2, 0, 0, 1, 0, 0, 0, 0, CODE_FAIL},
      '{32'h0600_0000, 32'h103, 0, 0, 1, 0, 0, 0, 0, CODE_FAIL},
      '{32'h0a00_0000, 0, 0, 0, 0, 0, 0, 0, 0, CODE_FAIL}};

   fscm_mailbox dut_u (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_ack, .mem_rdata, .fl_req, .fl_erase_all, .fl_addr, .fl_data,
      .fl_skip_blank, .fl_blocking, .fl_irq_mask, .fl_done, .fl_fail,
      .main_array_write_permit, .syscall_irq_line, .release_irq_line);
   fscm_far_model far_u (.clk, .rst_n, .slow, .fail, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_ack, .mem_rdata, .fl_req, .fl_done, .fl_fail);

   // Clock and hang guard
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end

   // Counts notifications and captures each flash request
   always @(posedge clk) begin
      fr_p <= fl_req;
      ir_p <= syscall_irq_line;
      if (syscall_irq_line && !ir_p) irq_cnt <= irq_cnt + 1;
      if (fl_req && !fr_p) begin
         fl_cnt <= fl_cnt + 1;
         er_s   <= fl_erase_all;
         ad_s   <= fl_addr;
         da_s   <= fl_data;
         fg_s   <= {fl_skip_blank, fl_blocking, fl_irq_mask};
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] wd);
      @(posedge clk);
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_address   <= a;
      avs_writedata <= wd;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   // Lock, post the block address, notify
   task automatic post(input logic [31:0] w0);
      far_u.mem[4] = w0;
      av(1'b0, OFS_LOCK, 32'h0);
      check("lock", rd, 32'h1);
      av(1'b1, OFS_DATA, 32'h10);
      av(1'b1, OFS_NOTIFY, 32'h1);
   endtask

   task automatic finish_test();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("idle outs", 32'({mem_req, fl_req, main_array_write_permit, syscall_irq_line,
         release_irq_line, avs_waitrequest}), 32'h0);
      foreach (rows[i]) begin
         r = rows[i];
         slow <= i[0];
         fail <= r.fail;
         {far_u.mem[5], far_u.mem[6], far_u.mem[7]} = {r.w1, r.w2, 32'h30};
         {far_u.mem[12], far_u.mem[13]} = {r.d0, ~r.d0};
         n_fl = fl_cnt;
         n_irq = irq_cnt;
         av(1'b1, OFS_CTRL, 32'(r.permit));
         @(posedge clk);
         check("permit", 32'(main_array_write_permit), 32'(r.permit));
         post(r.w0);
         while (release_irq_line !== 1'b1) @(posedge clk);
         check("code", far_u.mem[4], r.code);
         check("notify", 32'(irq_cnt - n_irq), 32'h1);
         check("flash ops", 32'(fl_cnt - n_fl), 32'(r.op));
         if (r.op) check("erase", 32'(er_s), 32'(r.erase));
         if (r.op && !r.erase) begin
            check("addr", ad_s, r.w2);
            check("data lo", da_s[31:0], r.d0);
            check("data hi", da_s[63:32], ~r.d0);
            check("flags", 32'(fg_s), 32'(r.flags));
         end
         av(1'b0, OFS_STATUS, 32'h0);
         check("status", rd, {27'h0, r.code === CODE_OK, 4'b0100});
         av(1'b1, OFS_STATUS, 32'h4);
      end
      // Unmapped place, notify without lock, double acquire
      av(1'b1, 5'h14, 32'hffff_ffff);
      av(1'b0, 5'h14, 32'h0);
      check("unmapped", rd, 32'h0);
      n_irq = irq_cnt;
      av(1'b1, OFS_NOTIFY, 32'h1);
      repeat (20) @(posedge clk);
      check("no lock notify", 32'(irq_cnt - n_irq), 32'h0);
      slow <= 1'b1;
      fail <= 1'b0;
      av(1'b1, OFS_CTRL, 32'h1);
      post(32'h0a00_0000);
      av(1'b0, OFS_LOCK, 32'h0);
      check("lock held", rd, 32'h0);
      while (release_irq_line !== 1'b1) @(posedge clk);
      av(1'b1, OFS_STATUS, 32'h4);
      av(1'b0, OFS_STATUS, 32'h0);
      check("cleared", rd, 32'h10);
      // Reset in mid-command, lock free afterwards
      post(32'h0a00_0000);
      while (fl_req !== 1'b1) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check("reset outs", 32'({mem_req, fl_req, main_array_write_permit, release_irq_line}),
         32'h0);
      rst_n <= 1'b1;
      av(1'b0, OFS_LOCK, 32'h0);
      check("lock after reset", rd, 32'h1);
      finish_test();
   end
endmodule
